// ---- dlpf_framer.sv ----
// packet builder (transmit) and packet parser (receive) of the host end
// assumes: payload source keeps pace once a payload has started; the lane
// layer puts bit 0 of each byte on the wire first
//
// What this block does
// - long packet is 32-bit header, payload, then 16-bit checksum footer
// - header order: identifier byte, 16-bit byte count, correction byte
// - long payload is 0 to 65535 bytes, packet at least six bytes
// - byte count covers payload only, not header or footer
// - header code corrects one bit, detects two, over identifier and count
// - receiver takes exactly count payload bytes, then two footer bytes
// - payload is transparent, no byte value is a control code
// - builder always computes and sends the payload checksum
// - checksum of an empty payload is all ones
// - bits sent low first; count and checksum low byte first
// - payload is whole bytes; formats may need coarser multiples
// - short packet: identifier, zero to seven bytes, correction byte
// - short packet length comes from the type code alone
// - identifier holds channel tag in bits 7:6, type in 5:0
// - type code tells receiver how many bytes follow
// - after a packet the next data is a header or burst end
// - builder always computes and sends the header correction byte
// - each packet carries its own channel tag
// - host splits video streams into separate packets
// - at most one response-requesting packet per transmission, except one started in the T_CHI or T_SECC cycle of the packet before it
// - queued packets of a burst follow without gaps; a start in the T_CHI or T_SECC cycle adds a one-cycle gap inside the burst
// - reserved and unassigned type codes are never generated
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "dlpf_cfg.svh"
module dlpf_framer import dlpf_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // payload source
  input wire dlpf_byte_t pl_data_i,
  input wire logic pl_valid_i,
  output logic pl_ready_o,
  // transmit bytes to lane layer
  output dlpf_byte_t tx_byte_o,
  output logic tx_valid_o,
  output logic tx_burst_o,
  // receive bytes from lane layer
  input wire dlpf_byte_t rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic rx_burst_i,
  // received content
  output dlpf_byte_t rx_data_o,
  output logic rx_data_valid_o,
  output logic rx_pkt_done_o
);
  localparam logic [23:0] ECC_M [0:5] = '{`DLPF_ECC_M0, `DLPF_ECC_M1,
    `DLPF_ECC_M2, `DLPF_ECC_M3, `DLPF_ECC_M4, `DLPF_ECC_M5};

  // ****************************************
  // header code and type lookups
  // ****************************************
  function automatic logic [7:0] f_ecc(input logic [23:0] d);
    logic [7:0] e;
    e = `DLPF_ECC_NONE;
    for (int k = 0; k < 6; k++) begin
      e[k] = ^(d & ECC_M[k]);
    end
    f_ecc = e;
  endfunction : f_ecc

  // returns {uncorrectable, corrected, repaired data}
  function automatic logic [25:0] f_ecc_fix(input logic [23:0] d, input logic [7:0] e);
    logic [7:0] s;
    logic [5:0] col;
    logic [23:0] fd;
    logic hit;
    s = e ^ f_ecc(d);
    fd = d;
    hit = 1'b0;
    for (int i = 0; i < 24; i++) begin
      for (int k = 0; k < 6; k++) begin
        col[k] = ECC_M[k][i];
      end
      if (s == {2'b00, col}) begin
        fd[i] = ~fd[i];
        hit = 1'b1;
      end
    end
    if (e == `DLPF_ECC_NONE || s == 8'h00) begin
      f_ecc_fix = {2'b00, d};
    end else if (hit || $onehot(s)) begin
      f_ecc_fix = {2'b01, fd};
    end else begin
      f_ecc_fix = {2'b10, d};
    end
  endfunction : f_ecc_fix

  function automatic logic f_is_long(input logic [5:0] dt);
    casez (dt)
      6'b??1001, 6'b??1110: f_is_long = 1'b1;
      default: f_is_long = 1'b0;
    endcase
  endfunction : f_is_long

  function automatic logic f_reserved(input logic [5:0] dt);
    casez (dt)
      6'b??0001, 6'b??0010, 6'b???011, 6'b???100, 6'b???101: f_reserved = 1'b0;
      6'h06, 6'h37, 6'b??1001, 6'b??1110: f_reserved = 1'b0;
      default: f_reserved = 1'b1;
    endcase
  endfunction : f_reserved

  function automatic logic [2:0] f_short_n(input logic [5:0] dt);
    casez (dt)
      6'b???011, 6'b???100, 6'b???101: f_short_n = dt[5:3];
      default: f_short_n = 3'h0;
    endcase
  endfunction : f_short_n

  function automatic logic f_needs_rsp(input logic [5:0] dt);
    casez (dt)
      6'b???100, 6'h06: f_needs_rsp = 1'b1;
      default: f_needs_rsp = 1'b0;
    endcase
  endfunction : f_needs_rsp

  // ****************************************
  // register port
  // ****************************************
  logic [23:0] hdr_r;
  logic [2:0] rxcfg_r;
  logic [23:0] rxhdr_r;
  logic pend_r;
  logic [`DLPF_ST_HI:`DLPF_ST_LO] stk_r;
  logic [`DLPF_ST_HI:`DLPF_ST_LO] ev;
  logic rx_ecor, rx_eunc, rx_crce, rx_rese;
  dlpf_tx_e st_r, st_nxt;
  dlpf_rx_e rst_r, rst_nxt;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `DLPF_A_CTRL);
  wire wr_hdr = reg_wr_i && (reg_addr_i == `DLPF_A_HDR);
  wire wr_stat = reg_wr_i && (reg_addr_i == `DLPF_A_STAT);
  wire wr_rxcfg = reg_wr_i && (reg_addr_i == `DLPF_A_RXCFG);
  wire start_req = wr_ctrl && reg_wdata_i[`DLPF_CTRL_START];
  wire busy = (st_r != T_IDLE) || pend_r;
  wire [31:0] stat_v = {23'h000000, stk_r, tx_burst_o, busy};
  wire [31:0] rd_mux = (reg_addr_i == `DLPF_A_HDR) ? {8'h00, hdr_r} :
                       (reg_addr_i == `DLPF_A_STAT) ? stat_v :
                       (reg_addr_i == `DLPF_A_RXCFG) ? {29'h00000000, rxcfg_r} :
                       (reg_addr_i == `DLPF_A_RXHDR) ? {8'h00, rxhdr_r} : 32'h00000000;
  wire [`DLPF_ST_HI:`DLPF_ST_LO] stk_clr = wr_stat ? reg_wdata_i[`DLPF_ST_HI:`DLPF_ST_LO] :
                                                      `DLPF_STK_RST;
  // an event in the clearing cycle survives
  wire [`DLPF_ST_HI:`DLPF_ST_LO] stk_nxt = ev | (stk_r & ~stk_clr);

  // ****************************************
  // packet builder
  // ****************************************
  logic [23:0] cur_r;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] crc_r, crc_nxt, crc_step;
  logic [15:0] sp_r, sp_nxt;
  logic rsp_seen_r;
  dlpf_byte_t byte_nxt;
  logic emit_nxt, last, ld;

  wire [5:0] cur_dt = cur_r[5:0];
  wire [5:0] hdr_dt = hdr_r[5:0];
  wire take = pl_ready_o && pl_valid_i;
  wire at_gap = (st_r == T_IDLE) || last;
  wire res_hdr = f_reserved(hdr_dt);
  wire rsp_blk = rsp_seen_r && (st_r != T_IDLE) && f_needs_rsp(hdr_dt);
  wire launch_ok = pend_r && !res_hdr && !rsp_blk;
  wire [2:0] sp_pos = f_short_n(cur_dt) - cnt_r[2:0];

  dlpf_crc_step u_tx_crc (
    .crc_i(crc_r),
    .byte_i(pl_data_i),
    .crc_o(crc_step)
  );

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    crc_nxt = crc_r;
    sp_nxt = sp_r;
    byte_nxt = tx_byte_o;
    emit_nxt = 1'b0;
    last = 1'b0;
    ld = 1'b0;
    unique case (st_r)
      T_IDLE: ;
      T_ID: begin
        byte_nxt = cur_r[7:0];
        emit_nxt = 1'b1;
        sp_nxt = 16'h0000;
        cnt_nxt = {13'h0000, f_short_n(cur_dt)};
        if (f_is_long(cur_dt)) begin
          st_nxt = T_WLO;
        end else if (f_short_n(cur_dt) != 3'h0) begin
          st_nxt = T_SPRM;
        end else begin
          st_nxt = T_SECC;
        end
      end
      T_WLO: begin
        byte_nxt = cur_r[15:8];
        emit_nxt = 1'b1;
        st_nxt = T_WHI;
      end
      T_WHI: begin
        byte_nxt = cur_r[23:16];
        emit_nxt = 1'b1;
        st_nxt = T_ECC;
      end
      T_ECC: begin
        byte_nxt = f_ecc(cur_r);
        emit_nxt = 1'b1;
        crc_nxt = `DLPF_CRC_INIT;
        cnt_nxt = cur_r[23:8];
        st_nxt = (cur_r[23:8] == 16'h0000) ? T_CLO : T_PAY;
      end
      T_PAY: if (take) begin
        byte_nxt = pl_data_i;
        emit_nxt = 1'b1;
        crc_nxt = crc_step;
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          st_nxt = T_CLO;
        end
      end
      T_CLO: begin
        byte_nxt = crc_r[7:0];
        emit_nxt = 1'b1;
        st_nxt = T_CHI;
      end
      T_CHI: begin
        byte_nxt = crc_r[15:8];
        emit_nxt = 1'b1;
        last = 1'b1;
      end
      T_SPRM: if (take) begin
        byte_nxt = pl_data_i;
        emit_nxt = 1'b1;
        if (sp_pos == 3'h0) sp_nxt = {sp_r[15:8], pl_data_i};
        if (sp_pos == 3'h1) sp_nxt = {pl_data_i, sp_r[7:0]};
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          st_nxt = T_SECC;
        end
      end
      T_SECC: begin
        byte_nxt = f_ecc({sp_r, cur_r[7:0]});
        emit_nxt = 1'b1;
        last = 1'b1;
      end
    endcase
    // next packet joins the burst without a gap only if already queued
    if (at_gap) begin
      ld = launch_ok;
      st_nxt = launch_ok ? T_ID : T_IDLE;
    end
  end

  always_comb begin
    ev = `DLPF_STK_RST;
    ev[`DLPF_EV_RES] = at_gap && pend_r && res_hdr;
    ev[`DLPF_EV_RSP] = at_gap && pend_r && !res_hdr && rsp_blk;
    ev[`DLPF_EV_UND] = pl_ready_o && !pl_valid_i;
    ev[`DLPF_EV_ECOR] = rx_ecor;
    ev[`DLPF_EV_EUNC] = rx_eunc;
    ev[`DLPF_EV_CRC] = rx_crce;
    ev[`DLPF_EV_RXRES] = rx_rese;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hdr_r <= `DLPF_HDR_RST;
      rxcfg_r <= `DLPF_RXCFG_RST;
      pend_r <= 1'b0;
      stk_r <= `DLPF_STK_RST;
      reg_rdata_o <= 32'h00000000;
    end else begin
      if (wr_hdr) hdr_r <= reg_wdata_i[23:0];
      if (wr_rxcfg) rxcfg_r <= reg_wdata_i[2:0];
      pend_r <= (pend_r && !at_gap) || start_req;
      stk_r <= stk_nxt;
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= T_IDLE;
      cur_r <= `DLPF_HDR_RST;
      cnt_r <= 16'h0000;
      crc_r <= `DLPF_CRC_INIT;
      sp_r <= 16'h0000;
      rsp_seen_r <= 1'b0;
      tx_byte_o <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_burst_o <= 1'b0;
      pl_ready_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (ld) cur_r <= hdr_r;
      cnt_r <= cnt_nxt;
      crc_r <= crc_nxt;
      sp_r <= sp_nxt;
      if (st_nxt == T_IDLE) begin
        rsp_seen_r <= 1'b0;
      end else if (ld && f_needs_rsp(hdr_dt)) begin
        rsp_seen_r <= 1'b1;
      end
      tx_byte_o <= byte_nxt;
      tx_valid_o <= emit_nxt;
      tx_burst_o <= (st_nxt != T_IDLE) || emit_nxt;
      pl_ready_o <= (st_nxt == T_PAY) || (st_nxt == T_SPRM);
    end
  end

  // ****************************************
  // packet parser
  // ****************************************
  dlpf_byte_t rx_id_r, rx_lo_r;
  logic [15:0] rx_w_r, rx_cnt_r, rx_crc_r, rx_crc_step;

  wire rxb = rx_valid_i && rx_burst_i;
  wire [5:0] rx_dt = rx_id_r[5:0];
  wire [5:0] rx_dt_in = rx_byte_i[5:0];
  wire [25:0] rx_fix_l = f_ecc_fix({rx_w_r, rx_id_r}, rx_byte_i);
  wire [15:0] rx_foot = {rx_byte_i, rx_lo_r};
  // type is decided before the code byte arrives; a long payload is filtered on the corrected channel
  wire rx_match = !rxcfg_r[`DLPF_RXCFG_FILT] || (rx_id_r[7:6] == rxcfg_r[1:0]);
  wire [2:0] rx_pos = f_short_n(rx_dt) - rx_cnt_r[2:0];
  wire rx_in_data = (rst_r == R_PAY) || (rst_r == R_SPRM);

  dlpf_crc_step u_rx_crc (
    .crc_i(rx_crc_r),
    .byte_i(rx_byte_i),
    .crc_o(rx_crc_step)
  );

  always_comb begin
    rst_nxt = rst_r;
    rx_ecor = 1'b0;
    rx_eunc = 1'b0;
    rx_crce = 1'b0;
    rx_rese = 1'b0;
    if (!rx_burst_i) begin
      rst_nxt = R_ID;
    end else if (rx_valid_i) begin
      unique case (rst_r)
        R_ID: begin
          if (f_reserved(rx_dt_in)) begin
            rst_nxt = R_SKIP;
            rx_rese = 1'b1;
          end else if (f_is_long(rx_dt_in)) begin
            rst_nxt = R_WLO;
          end else begin
            rst_nxt = (f_short_n(rx_dt_in) != 3'h0) ? R_SPRM : R_SECC;
          end
        end
        R_WLO: rst_nxt = R_WHI;
        R_WHI: rst_nxt = R_ECC;
        R_ECC: begin
          rx_ecor = rx_fix_l[24];
          rx_eunc = rx_fix_l[25];
          if (rx_fix_l[25]) begin
            rst_nxt = R_SKIP;
          end else begin
            rst_nxt = (rx_fix_l[23:8] == 16'h0000) ? R_CLO : R_PAY;
          end
        end
        R_PAY: if (rx_cnt_r == 16'h0001) rst_nxt = R_CLO;
        R_CLO: rst_nxt = R_CHI;
        R_CHI: begin
          rst_nxt = R_ID;
          rx_crce = (rx_foot != `DLPF_FOOT_NONE) && (rx_foot != rx_crc_r);
        end
        R_SPRM: if (rx_cnt_r == 16'h0001) rst_nxt = R_SECC;
        R_SECC: begin
          rst_nxt = R_ID;
          rx_ecor = rx_fix_l[24];
          rx_eunc = rx_fix_l[25];
        end
        R_SKIP: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_r <= R_ID;
      rx_id_r <= 8'h00;
      rx_lo_r <= 8'h00;
      rx_w_r <= 16'h0000;
      rx_cnt_r <= 16'h0000;
      rx_crc_r <= `DLPF_CRC_INIT;
      rxhdr_r <= `DLPF_HDR_RST;
      rx_data_o <= 8'h00;
      rx_data_valid_o <= 1'b0;
      rx_pkt_done_o <= 1'b0;
    end else begin
      rst_r <= rst_nxt;
      rx_data_o <= rx_byte_i;
      rx_data_valid_o <= rxb && rx_in_data && rx_match;
      rx_pkt_done_o <= rxb && rx_match && (((rst_r == R_CHI)) ||
                       ((rst_r == R_SECC) && !rx_fix_l[25]));
      if (rxb) begin
        unique case (rst_r)
          R_ID: begin
            rx_id_r <= rx_byte_i;
            rx_w_r <= 16'h0000;
            rx_cnt_r <= {13'h0000, f_short_n(rx_dt_in)};
          end
          R_WLO: rx_w_r <= {rx_w_r[15:8], rx_byte_i};
          R_WHI: rx_w_r <= {rx_byte_i, rx_w_r[7:0]};
          R_ECC: begin
            rx_id_r <= rx_fix_l[7:0];
            rx_cnt_r <= rx_fix_l[23:8];
            rx_crc_r <= `DLPF_CRC_INIT;
            if (rx_match) rxhdr_r <= rx_fix_l[23:0];
          end
          R_PAY: begin
            rx_crc_r <= rx_crc_step;
            rx_cnt_r <= rx_cnt_r - 16'h0001;
          end
          R_CLO: rx_lo_r <= rx_byte_i;
          R_SPRM: begin
            if (rx_pos == 3'h0) rx_w_r <= {rx_w_r[15:8], rx_byte_i};
            if (rx_pos == 3'h1) rx_w_r <= {rx_byte_i, rx_w_r[7:0]};
            rx_cnt_r <= rx_cnt_r - 16'h0001;
          end
          R_SECC: if (rx_match) rxhdr_r <= rx_fix_l[23:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_empty_ck;
    (st_r == T_ECC) && (cur_r[23:8] == 16'h0000) |-> ##2 (tx_byte_o == 8'hFF) ##1 (tx_byte_o == 8'hFF);
  endproperty
  a_empty_ck: assert property (p_empty_ck) else $error("empty checksum not ones");
  property p_count_order;
    st_r == T_WLO |=> tx_valid_o && (tx_byte_o == cur_r[15:8]) ##1 (tx_byte_o == cur_r[23:16]);
  endproperty
  a_count_order: assert property (p_count_order) else $error("count byte order");
  property p_hdr_code;
    st_r == T_ECC |=> tx_valid_o && (tx_byte_o == f_ecc(cur_r));
  endproperty
  a_hdr_code: assert property (p_hdr_code) else $error("header code wrong");
  property p_id_first;
    $rose(tx_burst_o) |-> (st_r == T_ID) ##1 (tx_valid_o && tx_byte_o == cur_r[7:0]);
  endproperty
  a_id_first: assert property (p_id_first) else $error("burst not opened by id");
  property p_no_reserved;
    ld |-> !f_reserved(hdr_dt) ##1 !f_reserved(cur_dt);
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved type sent");
  property p_one_rsp;
    ld && f_needs_rsp(hdr_dt) |-> (st_r == T_IDLE) || !rsp_seen_r;
  endproperty
  a_one_rsp: assert property (p_one_rsp) else $error("second response packet");
  property p_no_gap;
    (st_r == T_CHI) && launch_ok |=> tx_burst_o && (st_r == T_ID) ##1 tx_valid_o;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap inside burst");
  property p_rx_count;
    rxb && (rst_r == R_ECC) && !rx_fix_l[25] |=> (rx_cnt_r == $past(rx_fix_l[23:8]));
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("payload count not loaded");
  property p_rx_filter;
    rx_data_valid_o |-> $past(rx_match) && $past(rx_in_data);
  endproperty
  a_rx_filter: assert property (p_rx_filter) else $error("foreign channel delivered");
  property p_rx_realign;
    !rx_burst_i |=> (rst_r == R_ID);
  endproperty
  a_rx_realign: assert property (p_rx_realign) else $error("no realign at burst end");
  property p_rx_crc_flag;
    rx_crce |=> stk_r[`DLPF_EV_CRC];
  endproperty
  a_rx_crc_flag: assert property (p_rx_crc_flag) else $error("checksum error lost");

  c_long_pkt: cover property ((st_r == T_PAY) ##[1:20] (st_r == T_CHI));
  c_short_pkt: cover property ((st_r == T_SPRM) ##[1:8] (st_r == T_SECC));
  c_two_in_burst: cover property ((st_r == T_CHI) && launch_ok);
  c_rx_corrected: cover property (rx_ecor);
endmodule : dlpf_framer

// ---- dlpf_cfg.svh ----
// constants of the display link packet framer: register map, field
// positions, reset values, code polynomials
// assumes: included by bare name from every design file that needs it
`ifndef DLPF_CFG_SVH
`define DLPF_CFG_SVH

// ****************************************
// register map
// ****************************************
`define DLPF_A_CTRL 8'h00
`define DLPF_A_HDR 8'h04
`define DLPF_A_STAT 8'h08
`define DLPF_A_RXCFG 8'h0C
`define DLPF_A_RXHDR 8'h10
`define DLPF_CTRL_START 0
`define DLPF_HDR_RST 24'h000000
`define DLPF_RXCFG_RST 3'h0
`define DLPF_RXCFG_FILT 2
`define DLPF_ST_BUSY 0
`define DLPF_ST_BURST 1
`define DLPF_ST_LO 2
`define DLPF_ST_HI 8
`define DLPF_EV_RES 2
`define DLPF_EV_RSP 3
`define DLPF_EV_UND 4
`define DLPF_EV_ECOR 5
`define DLPF_EV_EUNC 6
`define DLPF_EV_CRC 7
`define DLPF_EV_RXRES 8
`define DLPF_STK_RST 7'h00

// ****************************************
// checksum and header code
// ****************************************
`define DLPF_CRC_INIT 16'hFFFF
`define DLPF_CRC_POLY 16'h8408
`define DLPF_FOOT_NONE 16'h0000
`define DLPF_ECC_NONE 8'h00
`define DLPF_ECC_M0 24'hF12CB7
`define DLPF_ECC_M1 24'hF2555B
`define DLPF_ECC_M2 24'h749A6D
`define DLPF_ECC_M3 24'hB8E38E
`define DLPF_ECC_M4 24'hDF03F0
`define DLPF_ECC_M5 24'hEFFC00

`endif

// ---- dlpf_pkg.sv ----
// types shared by the packet framer files
// assumes: nothing beyond a SystemVerilog compiler
package dlpf_pkg;
  typedef logic [7:0] dlpf_byte_t;
  typedef enum logic [3:0] {
    T_IDLE, T_ID, T_WLO, T_WHI, T_ECC, T_PAY, T_CLO, T_CHI, T_SPRM, T_SECC
  } dlpf_tx_e;
  typedef enum logic [3:0] {
    R_ID, R_WLO, R_WHI, R_ECC, R_PAY, R_CLO, R_CHI, R_SPRM, R_SECC, R_SKIP
  } dlpf_rx_e;
endpackage : dlpf_pkg

// ---- dlpf_crc_step.sv ----
// one byte step of the 16-bit payload checksum, bit 0 of the byte first
// assumes: caller holds the running value in its own register
`timescale 1ns/1ps
`include "dlpf_cfg.svh"
module dlpf_crc_step import dlpf_pkg::*; (
  // running value and next byte
  input wire logic [15:0] crc_i,
  input wire dlpf_byte_t byte_i,
  // updated value
  output logic [15:0] crc_o
);
  logic [15:0] c_v;

  always_comb begin
    c_v = crc_i;
    for (int i = 0; i < 8; i++) begin
      if (c_v[0] ^ byte_i[i]) begin
        c_v = (c_v >> 1) ^ `DLPF_CRC_POLY;
      end else begin
        c_v = c_v >> 1;
      end
    end
    crc_o = c_v;
  end
endmodule : dlpf_crc_step

// ---- dlpf_peer.sv ----
// partner model: peripheral lane end that hands every byte straight back, masked slots as zero
// assumes: shares the framer clock; bytes cross whole, one per cycle
`timescale 1ns/1ps
module dlpf_peer import dlpf_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // bytes from the framer
  input wire dlpf_byte_t tx_byte_i,
  input wire logic tx_valid_i,
  input wire logic tx_burst_i,
  // byte slots of a burst that a codeless peripheral sends as zero
  input wire logic [7:0] zero_mask_i,
  // bytes back into the framer
  output dlpf_byte_t rx_byte_o,
  output logic rx_valid_o,
  output logic rx_burst_o
);
  logic [7:0] pos_r;
  // only the first eight bytes of a burst can be blanked
  wire blank = tx_valid_i && (pos_r < 8'h08) && zero_mask_i[pos_r[2:0]];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_r <= 8'h00;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_burst_o <= 1'b0;
    end else begin
      // idle line flips so a stale byte never looks like data
      if (!tx_burst_i) begin
        pos_r <= 8'h00;
      end else if (tx_valid_i && pos_r != 8'hFF) begin
        pos_r <= pos_r + 8'h01;
      end
      rx_byte_o <= tx_valid_i ? (blank ? 8'h00 : tx_byte_i) : ~rx_byte_o;
      rx_valid_o <= tx_valid_i;
      rx_burst_o <= tx_burst_i;
    end
  end
endmodule : dlpf_peer

// ---- tb.sv ----
// self-checking bench: framer transmit looped back through the peer model
// assumes: dlpf_cfg.svh and dlpf_pkg compiled first
`timescale 1ns/1ps
`include "dlpf_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb import dlpf_pkg::*; ;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] zmask = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, pl_valid_i = 1'b1, pl_ready_o;
  dlpf_byte_t pl_data_i = 8'h00, tx_byte_o, rx_byte_i, rx_data_o;
  logic tx_valid_o, tx_burst_o, rx_valid_i, rx_burst_i, rx_data_valid_o, rx_pkt_done_o;
  dlpf_byte_t txq [$], rxq [$], plq [$];
  int err_total = 0, n_tests = 0, n_done = 0;
  logic [5:0] lt [8] = '{6'h09, 6'h19, 6'h29, 6'h39, 6'h0E, 6'h1E, 6'h2E, 6'h3E};
  logic [5:0] st [8] = '{6'h01, 6'h02, 6'h03, 6'h0B, 6'h13, 6'h0D, 6'h22, 6'h32};

  dlpf_framer dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pl_data_i(pl_data_i), .pl_valid_i(pl_valid_i),
    .pl_ready_o(pl_ready_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
    .tx_burst_o(tx_burst_o), .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
    .rx_burst_i(rx_burst_i), .rx_data_o(rx_data_o), .rx_data_valid_o(rx_data_valid_o),
    .rx_pkt_done_o(rx_pkt_done_o));
  dlpf_peer peer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tx_byte_i(tx_byte_o),
    .tx_valid_i(tx_valid_o), .tx_burst_i(tx_burst_o), .zero_mask_i(zmask), .rx_byte_o(rx_byte_i),
    .rx_valid_o(rx_valid_i), .rx_burst_o(rx_burst_i));

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************
  // expectations
  // ****************************************
  function automatic dlpf_byte_t ecc_of(input logic [23:0] v);
    logic [23:0] m [6];
    m = '{`DLPF_ECC_M0, `DLPF_ECC_M1, `DLPF_ECC_M2, `DLPF_ECC_M3, `DLPF_ECC_M4, `DLPF_ECC_M5};
    ecc_of = 8'h00;
    for (int i = 0; i < 6; i++)
      ecc_of[i] = ^(v & m[i]);
  endfunction : ecc_of

  function automatic logic [15:0] crc_of(input dlpf_byte_t q [$]);
    logic [15:0] c;
    c = `DLPF_CRC_INIT;
    foreach (q[i])
      for (int b = 0; b < 8; b++)
        c = (c[0] ^ q[i][b]) ? ((c >> 1) ^ `DLPF_CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_of

  // ****************************************
  // monitors, payload source, bus tasks
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (tx_valid_o === 1'b1) txq.push_back(tx_byte_o);
    if (rx_data_valid_o === 1'b1) rxq.push_back(rx_data_o);
    if (rx_pkt_done_o === 1'b1) n_done++;
    if (pl_ready_o === 1'b1 && pl_valid_i) begin
      plq.push_back(pl_data_i);
      pl_data_i <= 8'($urandom);
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  task automatic wait_lvl(input logic lvl, input int lim);
    int k;
    k = 0;
    while (tx_burst_o !== lvl && k < lim) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (k >= lim) begin
      err_total++;
      $display("BAD %0t burst wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_lvl

  // one packet out, compared on the wire and after loopback
  task automatic send(input dlpf_byte_t id, input logic [15:0] cnt, input bit lng, input bit acc);
    dlpf_byte_t exp [$];
    dlpf_byte_t pay [$];
    dlpf_byte_t p0, p1;
    int n0, np;
    txq = {};
    plq = {};
    rxq = {};
    n0 = n_done;
    np = (id[2:0] inside {3'h3, 3'h4, 3'h5}) ? int'(id[5:3]) : 0;
    wr(`DLPF_A_HDR, {8'h00, cnt, id});
    wr(`DLPF_A_CTRL, 32'h1);
    wait_lvl(1'b1, 20);
    wait_lvl(1'b0, 80);
    repeat (4) @(posedge ref_clk_i);
    pay = plq;
    p0 = pay.size() > 0 ? pay[0] : 8'h00;
    p1 = pay.size() > 1 ? pay[1] : 8'h00;
    exp = {id};
    if (lng) exp = {exp, cnt[7:0], cnt[15:8], ecc_of({cnt, id})};
    exp = {exp, pay};
    if (lng) exp = {exp, 8'(crc_of(pay)), 8'(crc_of(pay) >> 8)};
    else exp.push_back(ecc_of({p1, p0, id}));
    `CHK(pay.size(), lng ? int'(cnt) : np)
    `CHK(txq.size(), exp.size())
    foreach (exp[i]) `CHK(txq[i], exp[i])
    `CHK(rxq.size(), acc ? pay.size() : 0)
    foreach (rxq[i]) `CHK(rxq[i], pay[i])
    `CHK(n_done - n0, int'(acc))
    $display("packet %h done", id);
  endtask : send

  initial begin
    void'($urandom(85));
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(`DLPF_A_HDR, d);
    `CHK(d, 32'h0)
    rd(`DLPF_A_RXCFG, d);
    `CHK(d, 32'h0)
    rd(`DLPF_A_STAT, d);
    `CHK(d, 32'h0)
    rd(8'h14, d);
    `CHK(d, 32'h0)
    for (int k = 0; k < 8; k++) begin
      send({2'(k), lt[k]}, k == 0 ? 16'h0 : 16'($urandom_range(5, 1)), 1'b1, 1'b1);
      send({2'($urandom), st[k]}, 16'h0, 1'b0, 1'b1);
    end
    // own channel 2 with filtering on
    wr(`DLPF_A_RXCFG, 32'h6);
    send(8'h29, 16'h2, 1'b1, 1'b0);
    send(8'hA9, 16'h3, 1'b1, 1'b1);
    rd(`DLPF_A_RXHDR, d);
    `CHK(d, 32'h0003A9)
    // peer blanks code byte and footer of an empty long packet
    zmask <= 8'h38;
    send(8'h89, 16'h0, 1'b1, 1'b1);
    zmask <= 8'h00;
    rd(`DLPF_A_STAT, d);
    `CHK(d, 32'h0)
    txq = {};
    wr(`DLPF_A_HDR, 32'h0F);
    wr(`DLPF_A_CTRL, 32'h1);
    repeat (10) @(posedge ref_clk_i);
    `CHK(txq.size(), 0)
    rd(`DLPF_A_STAT, d);
    `CHK(d, 32'h4)
    wr(`DLPF_A_STAT, 32'h4);
    rd(`DLPF_A_STAT, d);
    `CHK(d, 32'h0)
    // second start arrives in the T_ID cycle, queued at the last byte: refused for a read, joined otherwise
    for (int r = 0; r < 2; r++) begin
      txq = {};
      wr(`DLPF_A_STAT, 32'h8);
      wr(`DLPF_A_HDR, r ? 32'h01 : 32'h04);
      wr(`DLPF_A_CTRL, 32'h1);
      wr(`DLPF_A_CTRL, 32'h1);
      repeat (10) @(posedge ref_clk_i);
      `CHK(txq.size(), r ? 4 : 2)
      rd(`DLPF_A_STAT, d);
      `CHK(d, r ? 32'h0 : 32'h8)
    end
    report_and_stop();
  end
endmodule : tb
